//--- design/fbw_watchdog.sv
module fbw_watchdog
    import fbw_pkg::*;
#(
    parameter int unsigned MON_LIMIT = MON_TICKS,
    parameter int unsigned TOG_LIMIT = TOG_TICKS
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire fbw_req_type req,
    input  wire fbw_cfg_type cfg,
    input  wire logic        param_port_bit_zero,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    output logic             red_fault_indicator,
    output logic             force_reset,
    output logic             exchange_disable,
    output logic             irq
);

    // ---------------------------------------------------------------------
    // Input synchronisation
    // ---------------------------------------------------------------------
    logic port_meta;
    logic port_sync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_meta <= 1'b0;
            port_sync <= 1'b0;
        end else begin
            port_meta <= param_port_bit_zero;
            port_sync <= port_meta;
        end
    end

    // ---------------------------------------------------------------------
    // Microsecond tick
    // ---------------------------------------------------------------------
    // The divider runs freely, so a newly started timer may see its first
    // tick early and time out up to one tick short of its limit.
    logic [$clog2(US_CYCLES)-1:0] div_count;
    logic                         us_tick;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_count <= '0;
            us_tick   <= 1'b0;
        end else if (div_count == ($clog2(US_CYCLES))'(US_CYCLES - 1)) begin
            div_count <= '0;
            us_tick   <= 1'b1;
        end else begin
            div_count <= div_count + 1'b1;
            us_tick   <= 1'b0;
        end
    end

    // ---------------------------------------------------------------------
    // Conditions
    // ---------------------------------------------------------------------
    logic addr_valid;
    logic wdg_mode;
    logic nibble_mode;
    logic exchange_seen;
    logic mon_expired;
    logic tog_expired;
    logic tog_restart;
    logic last_select;
    logic wdg_fire;
    logic tog_fire;

    assign addr_valid    = cfg.slave_addr != ADDR_ZERO;
    assign wdg_mode      = cfg.watchdog_enable
                         || (cfg.port_gated_watchdog_flag && port_sync);
    assign nibble_mode   = (cfg.id_code == ID_CODE_NIBBLE)
                         && cfg.extended_nibble_mode_bit && wdg_mode;
    assign exchange_seen = req.data_exchange || req.write_param;

    // ---------------------------------------------------------------------
    // Communication monitor
    // ---------------------------------------------------------------------
    fbw_state_type mon_state;

    // In watchdog mode a timeout stays armed for the one cycle of the forced
    // reset, which then disarms; only outside watchdog mode does it expire.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mon_state <= FBW_OFF;
        end else if (req.delete_addr || force_reset) begin
            mon_state <= FBW_OFF;
        end else begin
            unique case (mon_state)
                FBW_OFF: begin
                    if (req.write_param && addr_valid) begin
                        mon_state <= FBW_ARMED;
                    end
                end
                FBW_ARMED: begin
                    if (mon_expired && !exchange_seen && !wdg_mode) begin
                        mon_state <= FBW_EXPIRED;
                    end
                end
                FBW_EXPIRED: begin
                    if (exchange_seen) begin
                        mon_state <= FBW_ARMED;
                    end
                end
                // The unused code falls back to the disarmed state.
                default: begin
                    mon_state <= FBW_OFF;
                end
            endcase
        end
    end

    fbw_timer #(
        .LIMIT (MON_LIMIT),
        .WIDTH ($clog2(MON_LIMIT + 1))
    ) u_mon_timer (
        .clk     (clk),
        .arst_n  (arst_n),
        .tick    (us_tick),
        .restart (exchange_seen),
        .run     (mon_state == FBW_ARMED),
        .expired (mon_expired)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            red_fault_indicator <= 1'b0;
        end else begin
            // The LED follows the next state out of expiry, so a delete or forced reset darkens it at once.
            red_fault_indicator <= (mon_state == FBW_EXPIRED) && !exchange_seen
                                && !req.delete_addr && !force_reset;
        end
    end

    assign wdg_fire = (mon_state == FBW_ARMED) && mon_expired && !exchange_seen
                    && wdg_mode;

    // ---------------------------------------------------------------------
    // Toggle watchdog
    // ---------------------------------------------------------------------
    logic tog_armed;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tog_armed <= 1'b0;
        end else if (req.delete_addr || force_reset) begin
            tog_armed <= 1'b0;
        end else if (req.data_out_event && addr_valid) begin
            tog_armed <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_select <= 1'b0;
        end else if (req.data_exchange) begin
            // The select bit only means something during an exchange.
            last_select <= req.nibble_select_bit;
        end
    end

    // The master flips the select bit each exchange; a flip restarts the timer.
    assign tog_restart = (req.data_exchange && (req.nibble_select_bit != last_select))
                       || (req.data_out_event && !tog_armed);

    fbw_timer #(
        .LIMIT (TOG_LIMIT),
        .WIDTH ($clog2(TOG_LIMIT + 1))
    ) u_tog_timer (
        .clk     (clk),
        .arst_n  (arst_n),
        .tick    (us_tick),
        .restart (tog_restart),
        .run     (tog_armed && nibble_mode),
        .expired (tog_expired)
    );

    assign tog_fire = tog_armed && nibble_mode && tog_expired && !tog_restart;

    // ---------------------------------------------------------------------
    // Unconditioned reset and exchange disable
    // ---------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            force_reset <= 1'b0;
        end else begin
            // One cycle long: the reset disarms both supervisors on the next edge.
            force_reset <= (wdg_fire || tog_fire) && !force_reset;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            exchange_disable <= 1'b0;
        end else if (force_reset) begin
            // A forced reset wins over a parameter write in the same cycle.
            exchange_disable <= 1'b1;
        end else if (req.write_param) begin
            exchange_disable <= 1'b0;
        end
    end

    // ---------------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------------
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_enable;
    logic [IRQ_WIDTH-1:0] irq_event;
    logic                 mon_expired_d;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mon_expired_d <= 1'b0;
        end else begin
            mon_expired_d <= red_fault_indicator;
        end
    end

    // Each event is taken in its first cycle only, so a held condition counts once.
    always_comb begin
        irq_event                  = '0;
        irq_event[IRQ_MON_TIMEOUT] = red_fault_indicator && !mon_expired_d;
        irq_event[IRQ_WDG_RESET]   = wdg_fire && !force_reset;
        irq_event[IRQ_TOG_RESET]   = tog_fire && !force_reset;
    end

    // A set in the clearing cycle wins over the clear.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status <= '0;
        end else if (reg_write && reg_addr == REG_IRQ_CLEAR) begin
            irq_status <= (irq_status & ~reg_wdata[IRQ_WIDTH-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_enable <= '0;
        end else if (reg_write && reg_addr == REG_IRQ_ENABLE) begin
            irq_enable <= reg_wdata[IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status & irq_enable);

    // ---------------------------------------------------------------------
    // Register read port
    // ---------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            unique case (reg_addr)
                REG_STATUS: begin
                    reg_rdata <= {25'h0, wdg_mode, nibble_mode, tog_armed,
                                  exchange_disable, red_fault_indicator, mon_state};
                end
                REG_IRQ_STATUS: begin
                    reg_rdata <= {29'h0, irq_status};
                end
                REG_IRQ_ENABLE: begin
                    reg_rdata <= {29'h0, irq_enable};
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : fbw_watchdog

//--- design/fbw_pkg.sv
package fbw_pkg;

    // ---------------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ      = 125_000_000;
    // Monitor period 40.960 ms plus 5 % tolerance, in microseconds.
    localparam int unsigned MON_PERIOD_US    = 40_960;
    localparam int unsigned MON_TOL_PCT      = 5;
    localparam int unsigned MON_LIMIT_US     = MON_PERIOD_US + (MON_PERIOD_US * MON_TOL_PCT) / 100;
    // Toggle watchdog 327 ms plus 16 ms, in milliseconds.
    localparam int unsigned TOG_PERIOD_MS    = 327;
    localparam int unsigned TOG_TOL_MS       = 16;
    localparam int unsigned TOG_LIMIT_MS     = TOG_PERIOD_MS + TOG_TOL_MS;
    // A microsecond tick is the time base of both timers.
    localparam int unsigned US_CYCLES        = CLK_FREQ_HZ / 1_000_000;
    localparam int unsigned MON_TICKS        = MON_LIMIT_US;
    localparam int unsigned TOG_TICKS        = TOG_LIMIT_MS * 1000;

    // ---------------------------------------------------------------------
    // Configuration constants
    // ---------------------------------------------------------------------
    // Profile code that selects nibble mode; the value is arbitrary.
    localparam logic [3:0] ID_CODE_NIBBLE    = 4'h6;
    localparam logic [4:0] ADDR_ZERO         = 5'h00;

    // ---------------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------------
    typedef struct packed {
        logic data_exchange;
        logic write_param;
        logic delete_addr;
        logic data_out_event;
        logic nibble_select_bit;
    } fbw_req_type;

    typedef struct packed {
        logic       watchdog_enable;
        logic       port_gated_watchdog_flag;
        logic       extended_nibble_mode_bit;
        logic [3:0] id_code;
        logic [4:0] slave_addr;
    } fbw_cfg_type;

    // Register map of the software port.
    localparam logic [3:0] REG_STATUS     = 4'h0;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_CLEAR  = 4'h2;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h3;

    localparam int unsigned IRQ_MON_TIMEOUT = 0;
    localparam int unsigned IRQ_WDG_RESET   = 1;
    localparam int unsigned IRQ_TOG_RESET   = 2;
    localparam int unsigned IRQ_WIDTH       = 3;

    typedef enum logic [1:0] {
        FBW_OFF,
        FBW_ARMED,
        FBW_EXPIRED
    } fbw_state_type;

endpackage : fbw_pkg

//--- design/fbw_timer.sv
module fbw_timer
    import fbw_pkg::*;
#(
    parameter int unsigned LIMIT = 1000,
    parameter int unsigned WIDTH = 20
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic tick,
    input  wire logic restart,
    input  wire logic run,
    output logic      expired
);

    logic [WIDTH-1:0] count;

    // ---------------------------------------------------------------------
    // Counts ticks while running; restart and stop both clear it.
    // ---------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count   <= '0;
            expired <= 1'b0;
        end else if (restart || !run) begin
            count   <= '0;
            expired <= 1'b0;
        end else if (tick && !expired) begin
            if (count == WIDTH'(LIMIT - 1)) begin
                expired <= 1'b1;
            end
            count <= count + 1'b1;
        end
    end

endmodule : fbw_timer

//--- tb/fbw_watchdog_monitor.sv
module fbw_watchdog_monitor
    import fbw_pkg::*;
#(
    parameter int unsigned MON_LIMIT = MON_TICKS,
    parameter int unsigned TOG_LIMIT = TOG_TICKS
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire fbw_req_type req,
    input wire fbw_cfg_type cfg,
    input wire logic        param_port_bit_zero,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        red_fault_indicator,
    input wire logic        force_reset,
    input wire logic        exchange_disable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Cycles since the last exchange or parameter write
    // ---------------------------------------------------------------
    localparam int unsigned LO = (MON_LIMIT - 1) * US_CYCLES;
    localparam int unsigned HI = (MON_LIMIT + 1) * US_CYCLES + 4;
    logic [31:0] idle;
    logic        wdg;
    assign wdg = cfg.watchdog_enable || (cfg.port_gated_watchdog_flag && param_port_bit_zero);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle <= 32'h0;
        end else if (req.data_exchange || req.write_param) begin
            idle <= 32'h0;
        end else if (idle != 32'hFFFFFFFF) begin
            idle <= idle + 32'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_forced;
        force_reset ##1 (!force_reset && exchange_disable);
    endsequence
    a_force_single_pulse: assert property (force_reset |-> s_forced)
        else $error("force_reset did not pulse once and set exchange_disable");
    a_param_enables: assert property (req.write_param && !force_reset |=> !exchange_disable)
        else $error("exchange_disable not cleared by a parameter write");
    a_disable_holds: assert property (exchange_disable && !req.write_param |=> exchange_disable)
        else $error("exchange_disable dropped without a parameter write");
    a_led_off_exch: assert property (red_fault_indicator && req.data_exchange |=> !red_fault_indicator)
        else $error("red LED stayed on after an exchange");
    a_led_window: assert property ($rose(red_fault_indicator) |-> idle >= LO && idle <= HI)
        else $error("red LED lit outside the monitor window");
    a_delete_disarms: assert property (req.delete_addr |=> !(red_fault_indicator || force_reset) [*8])
        else $error("supervision still active after delete address");
    a_mode_needed: assert property (force_reset |-> cfg.watchdog_enable || cfg.port_gated_watchdog_flag)
        else $error("forced reset outside watchdog mode");
    a_led_not_wdg: assert property ($rose(red_fault_indicator) |-> !wdg)
        else $error("red LED lit in watchdog mode");
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
endmodule : fbw_watchdog_monitor

bind fbw_watchdog fbw_watchdog_monitor #(.MON_LIMIT(MON_LIMIT), .TOG_LIMIT(TOG_LIMIT)) u_monitor (
    .clk(clk), .arst_n(arst_n), .req(req), .cfg(cfg), .param_port_bit_zero(param_port_bit_zero),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .red_fault_indicator(red_fault_indicator),
    .force_reset(force_reset), .exchange_disable(exchange_disable)
);

//--- tb/fbw_master_model.sv
module fbw_master_model
    import fbw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        run,
    input  wire logic        toggle,
    input  wire logic [15:0] gap,
    input  wire logic        send_wp,
    input  wire logic        send_del,
    output fbw_req_type      req
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Periodic exchanges; with toggle set, the nibble select bit is inverted between them
    // ---------------------------------------------------------------
    logic [15:0] cnt;
    logic        sel;
    logic        xchg;
    logic        wp;
    logic        del;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 16'h0;
            sel <= 1'b0;
            xchg <= 1'b0;
            wp <= 1'b0;
            del <= 1'b0;
        end else begin
            xchg <= run && cnt >= gap;
            cnt <= (run && cnt < gap) ? cnt + 16'h1 : 16'h0;
            sel <= (run && cnt >= gap && toggle) ? ~sel : sel;
            wp <= send_wp;
            del <= send_del;
        end
    end
    assign req = '{data_exchange: xchg, write_param: wp, delete_addr: del,
                   data_out_event: xchg, nibble_select_bit: xchg ? sel : ~sel};
endmodule : fbw_master_model

//--- tb/fbw_watchdog_bench.sv
module fbw_watchdog_bench
    import fbw_pkg::*;
#(parameter int unsigned MON_SIM = 20, parameter int unsigned TOG_SIM = 50);
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    fbw_req_type req;
    fbw_cfg_type cfg = '0;
    logic        param_port_bit_zero = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata, d;
    logic        red, frc, xdis, irq;
    logic        run = 1'b0;
    logic        toggle = 1'b0;
    logic [15:0] gap = 16'h0;
    logic [1:0]  send = 2'b00;
    logic [31:0] rnd = 32'h7B61D74A;
    int          err_count = 0;
    int          compares = 0;
    int          n;
    always #4 clk = ~clk;
    fbw_watchdog #(.MON_LIMIT(MON_SIM), .TOG_LIMIT(TOG_SIM)) dut (
        .clk(clk), .arst_n(arst_n), .req(req), .cfg(cfg), .param_port_bit_zero(param_port_bit_zero),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .red_fault_indicator(red), .force_reset(frc),
        .exchange_disable(xdis), .irq(irq));
    fbw_master_model partner (.clk(clk), .arst_n(arst_n), .run(run), .toggle(toggle), .gap(gap),
        .send_wp(send[0]), .send_del(send[1]), .req(req));
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int cyc(input int unsigned ticks);
        return ticks * US_CYCLES;
    endfunction : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_rd
    task automatic pulse(input int k);
        @(posedge clk);
        send[k] <= 1'b1;
        @(posedge clk);
        send[k] <= 1'b0;
    endtask : pulse
    task automatic wait_hi(input bit k, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (n < lim && !(k ? frc : red));
    endtask : wait_hi
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        conclude();
    end
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1 chk({red, frc, xdis, irq}, 4'h0);
        for (int a = 0; a < 4; a++) begin
            reg_rd(a[3:0]);
            chk(d, 32'h0);
        end
        reg_wr(REG_STATUS, 32'hFFFFFFFF);
        reg_rd(REG_STATUS);
        chk(d, 32'h0);
        reg_rd(4'hF);
        chk(d, 32'h0);
        rnd = lfsr(rnd);
        reg_wr(REG_IRQ_ENABLE, rnd);
        reg_rd(REG_IRQ_ENABLE);
        chk(d, {29'h0, rnd[2:0]});
        reg_wr(REG_IRQ_ENABLE, 32'h0);
        $display("Test registers finished");
        pulse(0);
        wait_hi(0, cyc(MON_SIM * 2));
        chk(n, cyc(MON_SIM * 2));
        rnd = lfsr(rnd);
        @(posedge clk);
        cfg.slave_addr <= rnd[4:0] | 5'h01;
        gap <= {5'h0, rnd[10:0]};
        run <= 1'b1;
        pulse(0);
        wait_hi(0, 8000);
        chk(n, 8000);
        run <= 1'b0;
        pulse(0);
        wait_hi(0, cyc(MON_SIM + 1) + 8);
        chk({red, n > cyc(MON_SIM - 1)}, 2'b11);
        reg_rd(REG_IRQ_STATUS);
        chk(d, 32'h1 << IRQ_MON_TIMEOUT);
        chk(irq, 1'b0);
        reg_wr(REG_IRQ_ENABLE, 32'h7);
        #1 chk(irq, 1'b1);
        reg_wr(REG_IRQ_CLEAR, 32'h7);
        #1 chk(irq, 1'b0);
        gap <= 16'h4;
        run <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk(red, 1'b0);
        run <= 1'b0;
        wait_hi(0, 3000);
        chk(red, 1'b1);
        pulse(1);
        wait_hi(0, 3000);
        chk(n, 3000);
        $display("Test monitor finished");
        reg_wr(REG_IRQ_CLEAR, 32'h7);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            cfg.watchdog_enable <= (m == 0);
            cfg.port_gated_watchdog_flag <= (m != 0);
            param_port_bit_zero <= (m == 1);
            pulse(0);
            wait_hi(m != 2, cyc(MON_SIM + 1) + 8);
            chk({frc, red}, (m == 2) ? 2'b01 : 2'b10);
            if (m != 2) begin
                @(posedge clk);
                #1 chk({xdis, red}, 2'b10);
                reg_rd(REG_IRQ_STATUS);
                chk(d, 32'h1 << IRQ_WDG_RESET);
                pulse(0);
                @(posedge clk);
                #1 chk(xdis, 1'b0);
            end else begin
                reg_rd(REG_STATUS);
                chk(d, 32'h6);
                pulse(1);
            end
            reg_wr(REG_IRQ_CLEAR, 32'h7);
        end
        $display("Test watchdog mode finished");
        @(posedge clk);
        cfg.id_code <= ID_CODE_NIBBLE;
        cfg.extended_nibble_mode_bit <= 1'b1;
        cfg.watchdog_enable <= 1'b1;
        gap <= 16'd400;
        toggle <= 1'b1;
        run <= 1'b1;
        pulse(0);
        wait_hi(1, cyc(TOG_SIM * 2));
        chk(n, cyc(TOG_SIM * 2));
        toggle <= 1'b0;
        wait_hi(1, cyc(TOG_SIM + 1) + 500);
        chk({frc, n > cyc(TOG_SIM - 1) - 410}, 2'b11);
        reg_rd(REG_IRQ_STATUS);
        chk(d, 32'h1 << IRQ_TOG_RESET);
        @(posedge clk);
        cfg.extended_nibble_mode_bit <= 1'b0;
        pulse(0);
        wait_hi(1, cyc(TOG_SIM * 2));
        chk(n, cyc(TOG_SIM * 2));
        run <= 1'b0;
        $display("Test toggle finished");
        conclude();
    end
endmodule : fbw_watchdog_bench
